//--- include/seagg_regs.vh
// constants for the severity error collector
// assumes inclusion by design files under logic/
`ifndef SEAGG_REGS_VH
`define SEAGG_REGS_VH
`define SEAGG_G1_CHANNELS 64
`define SEAGG_G2_CHANNELS 32
`define SEAGG_G3_CHANNELS 32
`define SEAGG_CH_CONV2_PARITY 1
`define SEAGG_CH_DMA_MPU 2
`define SEAGG_CH_DMA_PARITY 3
`define SEAGG_CH_DMA_RD_ERR 5
`define SEAGG_CH_FLASH_CORR 6
`define SEAGG_CH_TCOPROC_PARITY 7
`define SEAGG_CH_TTRANS_PARITY 8
`define SEAGG_CH_TTRANS_MPU 9
`define SEAGG_CH_PLL_SLIP 10
`define SEAGG_CH_CLK_MON 11
`define SEAGG_CH_DMA_WR_ERR 13
`define SEAGG_CH_VIRQ_PARITY 15
`define SEAGG_CH_BSER1_PARITY 17
`define SEAGG_RESERVED_MASK 64'h0000_0000_0001_5011
`define SEAGG_PRESCALE_RST 16'h0000
`define SEAGG_LOW_TIME_RST 16'h0000
`endif

//--- logic/seagg_collector.v
// severity error collector: three groups, interrupts and fault pin
// assumes sources give one-cycle or level error strobes on core_clk
`timescale 1ns/100ps
`default_nettype none
`include "seagg_regs.vh"
// Summary of operation
// - 128 error inputs are taken in three groups, each handled by its group.
// - group one has 64 channels with maskable interrupts and per-channel pin enable.
// - each group one channel is routed to the low or high priority interrupt.
// - group two has 32 channels raising unmaskable high interrupt, always pin.
// - group three has 32 channels that only drive the fault pin.
// - group one is least severe and group three most severe.
// - a pin-enabled error drives the fault pin low for an external monitor.
// - fault pin low time is counted on a configurable prescaled timebase.
// - dma imprecise read error is channel 5 and write error channel 13.
// - flash interface correctable errors arrive on group one channel 6.
// - parity errors map to channels 1, 3, 7, 8, 15 and 17 of group one.
// - protection violations map to group one channels 2 and 9.
// - pll slip is channel 10 and clock monitor is channel 11 of group one.
module seagg_collector #(
	parameter G1N = 64,
	parameter G2N = 32,
	parameter G3N = 32,
	parameter CW = 16
)(
	input wire core_clk,
	input wire rst_b,
	input wire conv2_parity_err,
	input wire dma_mpu_err,
	input wire dma_parity_err,
	input wire dma_rd_err,
	input wire flash_corr_err,
	input wire tcoproc_parity_err,
	input wire ttrans_parity_err,
	input wire ttrans_mpu_err,
	input wire pll_slip_err,
	input wire clk_mon_err,
	input wire dma_wr_err,
	input wire virq_parity_err,
	input wire bser1_parity_err,
	input wire [G1N-1:0] g1_other_err,
	input wire [G2N-1:0] g2_err,
	input wire [G3N-1:0] g3_err,
	input wire [G1N-1:0] g1_irq_en,
	input wire [G1N-1:0] g1_irq_high,
	input wire [G1N-1:0] g1_pin_en,
	input wire [G1N-1:0] g1_clr,
	input wire [G2N-1:0] g2_clr,
	input wire [G3N-1:0] g3_clr,
	input wire force_err,
	input wire [1:0] force_group,
	input wire [6:0] force_chan,
	input wire [CW-1:0] pin_prescale,
	input wire [CW-1:0] pin_low_time,
	input wire pin_release,
	output reg [G1N-1:0] g1_stat_q,
	output reg [G2N-1:0] g2_stat_q,
	output reg [G3N-1:0] g3_stat_q,
	output wire irq_low,
	output wire irq_high,
	output wire fault_pin_n,
	output wire fault_active
);
	reg [G1N-1:0] g1_map;
	reg [G1N-1:0] g1_force;
	reg [G2N-1:0] g2_force;
	reg [G3N-1:0] g3_force;
	wire [G1N-1:0] g1_in;
	wire [G2N-1:0] g2_in;
	wire [G3N-1:0] g3_in;
	wire [G1N-1:0] g1_new;
	wire pin_event;
	wire [G1N-1:0] g1_low_req;
	wire [G1N-1:0] g1_high_req;
	wire [G1N-1:0] g1_pin_req;
	wire [G2N-1:0] g2_new;
	wire [G3N-1:0] g3_new;
	wire g1_low_any;
	wire g1_high_any;
	wire g1_pin_any;
	wire g2_any;
	wire g2_new_any;
	wire g3_new_any;
	genvar i;

	// named sources onto fixed group one channels
	always @*
	begin
		g1_map = g1_other_err;
		g1_map[`SEAGG_CH_CONV2_PARITY] = conv2_parity_err;
		g1_map[`SEAGG_CH_DMA_MPU] = dma_mpu_err;
		g1_map[`SEAGG_CH_DMA_PARITY] = dma_parity_err;
		g1_map[`SEAGG_CH_DMA_RD_ERR] = dma_rd_err;
		g1_map[`SEAGG_CH_FLASH_CORR] = flash_corr_err;
		g1_map[`SEAGG_CH_TCOPROC_PARITY] = tcoproc_parity_err;
		g1_map[`SEAGG_CH_TTRANS_PARITY] = ttrans_parity_err;
		g1_map[`SEAGG_CH_TTRANS_MPU] = ttrans_mpu_err;
		g1_map[`SEAGG_CH_PLL_SLIP] = pll_slip_err;
		g1_map[`SEAGG_CH_CLK_MON] = clk_mon_err;
		g1_map[`SEAGG_CH_DMA_WR_ERR] = dma_wr_err;
		g1_map[`SEAGG_CH_VIRQ_PARITY] = virq_parity_err;
		g1_map[`SEAGG_CH_BSER1_PARITY] = bser1_parity_err;
	end

	// force decode; force_group 0 is group one
	always @*
	begin
		g1_force = {G1N{1'b0}};
		g2_force = {G2N{1'b0}};
		g3_force = {G3N{1'b0}};
		if (force_err)
		begin
			// upper channel bits are ignored, so no index can fall outside
			case (force_group)
				2'h0:
				begin
					g1_force[force_chan[5:0]] = 1'b1;
				end
				2'h1:
				begin
					g2_force[force_chan[4:0]] = 1'b1;
				end
				2'h2:
				begin
					g3_force[force_chan[4:0]] = 1'b1;
				end
				default:
				begin
					g1_force = {G1N{1'b0}};
				end
			endcase
		end
	end

	// reserved channels masked even against forcing: they do not exist
	assign g1_in = (g1_map | g1_force) & ~`SEAGG_RESERVED_MASK;
	assign g2_in = g2_err | g2_force;
	assign g3_in = g3_err | g3_force;
	assign g1_new = g1_in & ~g1_stat_q;

	// sticky status per channel; a new error wins over a clear
	generate
		for (i = 0; i < G1N; i = i + 1)
		begin : g1_bit
			always @(posedge core_clk)
			begin
				if (!rst_b)
				begin
					g1_stat_q[i] <= 1'b0;
				end
				else if (g1_in[i])
				begin
					g1_stat_q[i] <= 1'b1;
				end
				else if (g1_clr[i])
				begin
					g1_stat_q[i] <= 1'b0;
				end
			end
			// the mask gates only the request, status still records it
			assign g1_low_req[i] = g1_stat_q[i] & g1_irq_en[i] &
				~g1_irq_high[i];
			assign g1_high_req[i] = g1_stat_q[i] & g1_irq_en[i] &
				g1_irq_high[i];
			assign g1_pin_req[i] = g1_new[i] & g1_pin_en[i];
		end
		for (i = 0; i < G2N; i = i + 1)
		begin : g2_bit
			always @(posedge core_clk)
			begin
				if (!rst_b)
				begin
					g2_stat_q[i] <= 1'b0;
				end
				else if (g2_in[i])
				begin
					g2_stat_q[i] <= 1'b1;
				end
				else if (g2_clr[i])
				begin
					g2_stat_q[i] <= 1'b0;
				end
			end
			// pin effect is fixed: every new error counts
			assign g2_new[i] = g2_in[i] & ~g2_stat_q[i];
		end
		for (i = 0; i < G3N; i = i + 1)
		begin : g3_bit
			always @(posedge core_clk)
			begin
				if (!rst_b)
				begin
					g3_stat_q[i] <= 1'b0;
				end
				else if (g3_in[i])
				begin
					g3_stat_q[i] <= 1'b1;
				end
				else if (g3_clr[i])
				begin
					g3_stat_q[i] <= 1'b0;
				end
			end
			// no interrupt path exists for this group
			assign g3_new[i] = g3_in[i] & ~g3_stat_q[i];
		end
	endgenerate

	// interrupt levels follow the sticky status
	assign g1_low_any = |g1_low_req;
	assign g1_high_any = |g1_high_req;
	assign g2_any = |g2_stat_q;
	assign irq_low = g1_low_any;
	// group two bypasses every mask; group three never interrupts
	assign irq_high = g1_high_any | g2_any;

	// only rising errors restart the pin; a held level does not retrigger
	assign g1_pin_any = |g1_pin_req;
	assign g2_new_any = |g2_new;
	assign g3_new_any = |g3_new;
	assign pin_event = g1_pin_any | g2_new_any | g3_new_any;

	seagg_pin_timer #(
		.CW(CW)
	) u_pin (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.fault_req(pin_event),
		.fault_release(pin_release),
		.prescale(pin_prescale),
		.low_time(pin_low_time),
		.fault_pin_n(fault_pin_n),
		.fault_active(fault_active)
	);
endmodule
`default_nettype wire

//--- logic/seagg_pin_timer.v
// fault pin timing: holds the pin low at least a configurable number of ticks, then until release
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "seagg_regs.vh"
module seagg_pin_timer #(
	parameter CW = 16
)(
	input wire core_clk,
	input wire rst_b,
	input wire fault_req,
	input wire fault_release,
	input wire [CW-1:0] prescale,
	input wire [CW-1:0] low_time,
	output reg fault_pin_n,
	output wire fault_active
);
	reg [CW-1:0] div_q;
	reg [CW-1:0] cnt_q;
	reg act_q;
	wire tick;
	// tick enable from the prescaler, one cycle wide, held high every cycle while prescale is zero
	assign tick = (div_q == prescale);
	assign fault_active = act_q;
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			div_q <= `SEAGG_PRESCALE_RST;
			cnt_q <= `SEAGG_LOW_TIME_RST;
			act_q <= 1'b0;
			fault_pin_n <= 1'b1;
		end
		else
		begin
			if (tick)
				div_q <= {CW{1'b0}};
			else
				div_q <= div_q + {{(CW-1){1'b0}}, 1'b1};
			if (fault_req)
			begin
				// a new fault restarts the low period
				act_q <= 1'b1;
				cnt_q <= {CW{1'b0}};
				fault_pin_n <= 1'b0;
			end
			else if (act_q)
			begin
				if (tick && cnt_q != low_time)
					cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
				// release only once the minimum low time elapsed
				if (fault_release && cnt_q == low_time)
				begin
					act_q <= 1'b0;
					fault_pin_n <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/seagg_chk_assertions.sv
// port checker for the severity error collector
// assumes binding onto seagg_collector, one clock
`timescale 1ns/100ps
`default_nettype none
module seagg_chk (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic dma_rd_err,
	input wire logic dma_wr_err,
	input wire logic pll_slip_err,
	input wire logic [31:0] g3_err,
	input wire logic [63:0] g1_irq_en,
	input wire logic [63:0] g1_irq_high,
	input wire logic [63:0] g1_stat_q,
	input wire logic [31:0] g2_stat_q,
	input wire logic [31:0] g3_stat_q,
	input wire logic irq_low,
	input wire logic irq_high,
	input wire logic fault_pin_n,
	input wire logic fault_active
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_b);
AST_RD: assert property (dma_rd_err |=> g1_stat_q[5])
	else $error("read error lost");
AST_WR: assert property (dma_wr_err |=> g1_stat_q[13])
	else $error("write error lost");
AST_PLL: assert property (pll_slip_err |=> g1_stat_q[10])
	else $error("slip lost");
AST_RSV: assert property ((g1_stat_q & 64'h15011) == 0)
	else $error("reserved set");
AST_LOW: assert property (irq_low == |(g1_stat_q & g1_irq_en & ~g1_irq_high))
	else $error("low irq wrong");
AST_G2: assert property (|g2_stat_q |-> irq_high)
	else $error("group two irq missing");
AST_G3: assert property (|(g3_err & ~g3_stat_q) |=> !fault_pin_n)
	else $error("group three pin missing");
AST_ACT: assert property (fault_active != fault_pin_n)
	else $error("active flag wrong");
C_LOW: cover property (irq_low);
C_HIGH: cover property (irq_high);
C_PIN: cover property ($fell(fault_pin_n));
endmodule
bind seagg_collector seagg_chk seagg_chk_i (.*);
`default_nettype wire

//--- tb/seagg_mon.sv
// monitor model: watches the fault pin and asks for its return
// assumes release is honoured once the low time has passed
`timescale 1ns/100ps
`default_nettype none
module seagg_mon (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic fault_pin_n,
	output logic pin_release,
	output logic [7:0] fall_cnt
);
logic last_q;
// held until the pin is seen high, never dropped early
always @(negedge core_clk)
begin
	pin_release <= rst_b && !fault_pin_n;
	last_q <= fault_pin_n;
	fall_cnt <= !rst_b ? 8'h00 : fall_cnt + (last_q && !fault_pin_n);
end
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the severity error collector
// assumes the monitor model releases the pin
`timescale 1ns/100ps
`default_nettype none
module tb;
logic core_clk = 0, rst_b = 0, fe = 0, rel, il, ih, pn, fa;
logic [12:0] nm = 0;
logic [63:0] o1 = 0, en = 0, hi = 0, pe = 0, cl = 0, e1, s1;
logic [31:0] g2 = 0, g3 = 0, e2, e3, s2, s3;
logic [1:0] fg = 0;
logic [7:0] fc;
logic [6:0] fch = 0;
logic [15:0] psc = 0, lt = 0;
int chs[13] = '{1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 13, 15, 17};
int error_cnt = 0, checks = 0, t, k, c, n, falls = 0;
seagg_collector seagg_collector_i (.core_clk(core_clk), .rst_b(rst_b),
	.conv2_parity_err(nm[0]), .dma_mpu_err(nm[1]), .dma_parity_err(nm[2]),
	.dma_rd_err(nm[3]), .flash_corr_err(nm[4]), .tcoproc_parity_err(nm[5]),
	.ttrans_parity_err(nm[6]), .ttrans_mpu_err(nm[7]), .pll_slip_err(nm[8]),
	.clk_mon_err(nm[9]), .dma_wr_err(nm[10]), .virq_parity_err(nm[11]),
	.bser1_parity_err(nm[12]), .g1_other_err(o1), .g2_err(g2), .g3_err(g3),
	.g1_irq_en(en), .g1_irq_high(hi), .g1_pin_en(pe), .g1_clr(cl),
	.g2_clr(cl[31:0]), .g3_clr(cl[63:32]), .force_err(fe), .force_group(fg),
	.force_chan(fch), .pin_prescale(psc), .pin_low_time(lt),
	.pin_release(rel), .g1_stat_q(s1), .g2_stat_q(s2), .g3_stat_q(s3),
	.irq_low(il), .irq_high(ih), .fault_pin_n(pn), .fault_active(fa));
seagg_mon seagg_mon_i (.core_clk(core_clk), .rst_b(rst_b),
	.fault_pin_n(pn), .pin_release(rel), .fall_cnt(fc));
initial
begin
	forever #2 core_clk = ~core_clk;
end
task chk(input string nme, input logic [63:0] e, input logic [63:0] s);
	checks++;
	if (s !== e)
	begin
		error_cnt++;
		$display("CHECK FAILED %s expected %h seen %h", nme, e, s);
	end
endtask
function logic pin_exp(input logic [63:0] a, b, input logic [31:0] x, y);
	return |(a & b) || |x || |y;
endfunction
task stop_test;
	$display("checks %0d error_cnt %0d", checks, error_cnt);
	if (error_cnt == 0 && checks > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
initial
begin
	void'($urandom(4578));
	psc = 16'($urandom % 3);
	lt = 16'(1 + $urandom % 3);
	repeat (3) @(negedge core_clk);
	rst_b = 1;
	for (t = 0; t < 100; t++)
	begin
		k = t < 3 ? t + 3 : $urandom % 5;
		c = t < 3 ? 16 + t : $urandom % 64;
		fg = t < 3 ? 2'h0 : 2'($urandom);
		en = {$urandom, $urandom};
		hi = {$urandom, $urandom};
		pe = {$urandom, $urandom};
		e1 = 0;
		e2 = 0;
		e3 = 0;
		fch = 7'(c);
		if (k == 0) nm[c % 13] = 1;
		if (k == 0) e1[chs[c % 13]] = 1;
		if (k == 1) o1[c] = 1;
		if (k == 1) e1[c] = c > 17;
		if (k == 2) g2[c % 32] = 1;
		if (k == 2 || (k > 3 && fg == 1)) e2[c % 32] = 1;
		if (k == 3) g3[c % 32] = 1;
		if (k == 3 || (k > 3 && fg == 2)) e3[c % 32] = 1;
		fe = k > 3;
		if (k > 3 && fg == 0) e1[c] = !((64'h15011 >> c) & 1);
		@(negedge core_clk);
		{nm, o1, g2, g3, fe} = 0;
		falls += pin_exp(e1, pe, e2, e3);
		chk("g1", e1, s1);
		chk("g2", e2, s2);
		chk("g3", e3, s3);
		chk("low", |(e1 & en & ~hi), il);
		chk("high", |(e1 & en & hi) || |e2, ih);
		chk("pin", !pin_exp(e1, pe, e2, e3), pn);
		chk("active", pin_exp(e1, pe, e2, e3), fa);
		cl = '1;
		@(negedge core_clk);
		cl = 0;
		for (n = 0; n < 20 && pn !== 1'b1; n++) @(negedge core_clk);
		if (n == 20)
		begin
			error_cnt++;
			$display("CHECK FAILED pin_return expected 1 seen %b", pn);
			stop_test();
		end
		chk("clear", 0, {|s1, |s2, |s3, il, ih});
	end
	chk("falls", 8'(falls), fc);
	stop_test();
end
endmodule
`default_nettype wire
